// ==== common/prot_pkg.sv ====
// constants for the program memory code protection block
package prot_pkg;
  localparam int ADDR_W = 22;
  localparam logic [21:0] BOOT_END = 22'h0001FF;
  localparam logic [21:0] BLK1_BASE = 22'h002000;
  localparam logic [21:0] BLK2_BASE = 22'h004000;
  localparam logic [21:0] BLK3_BASE = 22'h006000;
  localparam logic [21:0] IMPL_TOP_32K = 22'h007FFF;
  localparam logic [21:0] ID_BASE = 22'h200000;
  localparam logic [21:0] ID_LAST = 22'h200007;
  localparam logic [21:0] CFG_BASE = 22'h300000;
  localparam logic [21:0] CFG_LAST = 22'h30000F;
  localparam logic [21:0] DEVID_BASE = 22'h3FFFFE;
  localparam logic [21:0] REG_BLK_RDLOCK = 22'h300008;
  localparam logic [21:0] REG_BOOT_DATA_RDLOCK = 22'h300009;
  localparam logic [21:0] REG_BLK_WRLOCK = 22'h30000A;
  localparam logic [21:0] REG_BOOT_DATA_CFG_WRLOCK = 22'h30000B;
  localparam logic [21:0] REG_BLK_FRLOCK = 22'h30000C;
  localparam logic [21:0] REG_BOOT_FRLOCK = 22'h30000D;
  localparam int BIT_EEPROM_READ_LOCK = 7;
  localparam int BIT_BOOT_READ_LOCK = 6;
  localparam int BIT_EEPROM_WRITE_LOCK = 7;
  localparam int BIT_BOOT_WRITE_LOCK = 6;
  localparam int BIT_CONFIG_WRITE_LOCK = 5;
  localparam int BIT_BOOT_FOREIGN_READ_LOCK = 6;
  localparam logic [7:0] MASK_BLK = 8'h0F;
  localparam logic [7:0] MASK_BOOT_DATA = 8'hC0;
  localparam logic [7:0] MASK_WRLOCK_HI = 8'hE0;
  localparam logic [7:0] MASK_BOOT_FR = 8'h40;
  localparam logic [7:0] ERASED = 8'hFF;
  // block index: 0 boot, 1..4 user blocks 0..3, 5 unimplemented
  localparam logic [2:0] BLK_BOOT = 3'h0;
  localparam logic [2:0] BLK_NONE = 3'h5;
  // programmer commands
  typedef enum logic [2:0] {
    PCMD_READ,
    PCMD_WRITE,
    PCMD_CHIP_ERASE,
    PCMD_BLOCK_ERASE,
    PCMD_EE_READ,
    PCMD_EE_WRITE
  } pcmd_t;
endpackage

// ==== core/code_protect.sv ====
// access checking for program memory, data eeprom, id and configuration bytes
// Function
// - addresses 0 to 0001FFh form the 512-byte boot block with own bits
// - user blocks 0..3 start at 000200h, 002000h, 004000h, 006000h
// - each of five blocks has read, write and foreign-read locks
// - read locks ignored for user code; block programmer read and write
// - table write to a block with write lock 0 is blocked
// - foreign-read lock 0 still allows table reads fetched inside block
// - foreign-read lock 0 gives zeros to table reads from outside block
// - protection bits only program from 1 to 0
// - only programmer chip or block erase sets protection bits back to 1
// - eeprom read lock refuses all programmer eeprom reads and writes
// - eeprom write lock refuses programmer eeprom writes
// - core eeprom access is never restricted
// - config write lock is read-only to user code, programmer may change
// - table ops reach user memory, device id reads, config reads and writes
// - eight id locations 200000h..200007h reachable by table ops and programmer
// - id locations readable whatever the code protection
// - block lock bits sit in bits 3..0 at 300008h, 30000Ah, 30000Ch
// - programmer drives serial clock and voltage; link decoded outside this block
`timescale 1ns/1ns
module code_protect #(
  parameter int MEM_KBYTES = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  // processor core table unit
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [prot_pkg::ADDR_W-1:0] table_pointer,
  input wire logic [prot_pkg::ADDR_W-1:0] pc,
  input wire logic [7:0] table_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] table_latch,
  output logic table_done,
  output logic mem_write_en,
  output logic cfg_write_refused,
  // core eeprom access
  input wire logic core_ee_req,
  output logic core_ee_grant,
  // external programmer, commands decoded from the serial link
  input wire logic prog_req,
  input wire prot_pkg::pcmd_t prog_cmd,
  input wire logic [prot_pkg::ADDR_W-1:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  output logic prog_allow,
  output logic prog_refused,
  output logic [7:0] prog_rdata,
  output logic prog_done
);
  import prot_pkg::*;

  localparam logic [21:0] IMPL_TOP = (MEM_KBYTES == 16) ? 22'h003FFF : IMPL_TOP_32K;

  initial
  begin
    if (MEM_KBYTES != 16 && MEM_KBYTES != 32)
      $error("MEM_KBYTES must be 16 or 32");
  end

  // protection bits; 1 means unprotected, erased state
  logic [3:0] blk_read_lock;
  logic [3:0] blk_write_lock;
  logic [3:0] blk_foreign_read_lock;
  logic boot_read_lock;
  logic boot_write_lock;
  logic boot_foreign_read_lock;
  logic eeprom_read_lock;
  logic eeprom_write_lock;
  logic config_write_lock;

  // block decode, shared by core and programmer paths
  function automatic logic [2:0] block_of(input logic [21:0] a, input logic [21:0] top);
    if (a > top)
      block_of = BLK_NONE;
    else if (a <= BOOT_END)
      block_of = BLK_BOOT;
    else if (a < BLK1_BASE)
      block_of = 3'h1;
    else if (a < BLK2_BASE)
      block_of = 3'h2;
    else if (a < BLK3_BASE)
      block_of = 3'h3;
    else
      block_of = 3'h4;
  endfunction

  // pick one lock bit for a block, boot bit at index 0
  function automatic logic lock_of(input logic [2:0] b, input logic boot, input logic [3:0] blk);
    logic [4:0] all;
    all = {blk, boot};
    lock_of = (b == BLK_NONE) ? 1'b1 : all[b];
  endfunction

  function automatic logic is_cfg(input logic [21:0] a);
    is_cfg = (a >= CFG_BASE) && (a <= CFG_LAST);
  endfunction

  // current protection register image
  function automatic logic [7:0] cfg_byte(input logic [21:0] a);
    case (a)
      REG_BLK_RDLOCK: cfg_byte = {4'h0, blk_read_lock};
      REG_BOOT_DATA_RDLOCK: cfg_byte = {eeprom_read_lock, boot_read_lock, 6'h00};
      REG_BLK_WRLOCK: cfg_byte = {4'h0, blk_write_lock};
      REG_BOOT_DATA_CFG_WRLOCK:
        cfg_byte = {eeprom_write_lock, boot_write_lock, config_write_lock, 5'h00};
      REG_BLK_FRLOCK: cfg_byte = {4'h0, blk_foreign_read_lock};
      REG_BOOT_FRLOCK: cfg_byte = {1'b0, boot_foreign_read_lock, 6'h00};
      default: cfg_byte = 8'h00;
    endcase
  endfunction

  // core side decisions, evaluated from the current bits
  logic [2:0] tp_blk;
  logic [2:0] pc_blk;
  logic tp_mem;
  logic tp_id;
  logic tp_cfg;
  logic tp_devid;
  logic rd_allowed;
  logic wr_allowed;
  logic cfg_wr_ok;
  always_comb
  begin
    tp_blk = block_of(table_pointer, IMPL_TOP);
    pc_blk = block_of(pc, IMPL_TOP);
    tp_mem = table_pointer <= IMPL_TOP;
    tp_id = (table_pointer >= ID_BASE) && (table_pointer <= ID_LAST);
    tp_cfg = is_cfg(table_pointer);
    tp_devid = table_pointer >= DEVID_BASE;
    // read locks play no part here
    rd_allowed = tp_mem && ((pc_blk == tp_blk)
      || lock_of(tp_blk, boot_foreign_read_lock, blk_foreign_read_lock));
    wr_allowed = tp_mem && lock_of(tp_blk, boot_write_lock, blk_write_lock);
    cfg_wr_ok = config_write_lock;
  end

  // table latch load; unimplemented and locked reads give zeros
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      table_latch <= 8'h00;
    else if (table_read_op)
    begin
      if (rd_allowed || tp_id || tp_devid)
        table_latch <= mem_rdata;
      else if (tp_cfg)
        table_latch <= cfg_byte(table_pointer);
      else
        table_latch <= 8'h00;
    end
  end

  // one-cycle completion strobe for either table op
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      table_done <= 1'b0;
    else
      table_done <= table_read_op || table_write_op;
  end

  // memory write enable; config bytes changed by user only while unlocked
  always_comb
  begin
    mem_write_en = table_write_op && (wr_allowed || tp_id);
    cfg_write_refused = table_write_op && tp_cfg && !cfg_wr_ok;
  end

  assign core_ee_grant = core_ee_req;

  // programmer side decisions
  logic [2:0] pa_blk;
  logic pa_cfg;
  logic pa_id;
  logic blk_erase_all;
  always_comb
  begin
    pa_blk = block_of(prog_addr, IMPL_TOP);
    pa_cfg = is_cfg(prog_addr);
    pa_id = (prog_addr >= ID_BASE) && (prog_addr <= ID_LAST);
    blk_erase_all = 1'b0;
    case (prog_cmd)
      PCMD_READ:
        prog_allow = pa_id || pa_cfg
          || (prog_addr <= IMPL_TOP && lock_of(pa_blk, boot_read_lock, blk_read_lock));
      PCMD_WRITE:
        prog_allow = pa_id || (pa_cfg && config_write_lock)
          || (prog_addr <= IMPL_TOP && lock_of(pa_blk, boot_read_lock, blk_read_lock)
              && lock_of(pa_blk, boot_write_lock, blk_write_lock));
      PCMD_CHIP_ERASE, PCMD_BLOCK_ERASE:
        prog_allow = 1'b1;
      PCMD_EE_READ:
        prog_allow = eeprom_read_lock;
      PCMD_EE_WRITE:
        prog_allow = eeprom_read_lock && eeprom_write_lock;
      default:
        prog_allow = 1'b0;
    endcase
    if (prog_cmd == PCMD_CHIP_ERASE)
      blk_erase_all = 1'b1;
  end

  logic prog_ok;
  assign prog_ok = prog_req && prog_allow;

  // programmer answer, one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      prog_done <= 1'b0;
      prog_refused <= 1'b0;
      prog_rdata <= 8'h00;
    end
    else
    begin
      prog_done <= prog_req;
      prog_refused <= prog_req && !prog_allow;
      if (prog_req)
      begin
        if (!prog_allow || prog_cmd != PCMD_READ)
          prog_rdata <= 8'h00;
        else if (pa_cfg)
          prog_rdata <= cfg_byte(prog_addr);
        else if (prog_addr > IMPL_TOP && !pa_id)
          prog_rdata <= 8'h00;
        else
          prog_rdata <= mem_rdata;
      end
    end
  end

  // protection bits: cleared by writes, set only by programmer erase
  logic core_cfg_wr;
  logic prog_cfg_wr;
  logic [7:0] wr_byte;
  logic [21:0] wr_addr;
  always_comb
  begin
    core_cfg_wr = table_write_op && tp_cfg && cfg_wr_ok;
    prog_cfg_wr = prog_ok && prog_cmd == PCMD_WRITE && pa_cfg;
    wr_byte = prog_cfg_wr ? prog_wdata : table_wdata;
    wr_addr = prog_cfg_wr ? prog_addr : table_pointer;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      // erased image; the bits are non-volatile in silicon, reset models a blank part
      blk_read_lock <= 4'hF;
      blk_write_lock <= 4'hF;
      blk_foreign_read_lock <= 4'hF;
      boot_read_lock <= 1'b1;
      boot_write_lock <= 1'b1;
      boot_foreign_read_lock <= 1'b1;
      eeprom_read_lock <= 1'b1;
      eeprom_write_lock <= 1'b1;
      config_write_lock <= 1'b1;
    end
    else if (prog_ok && (blk_erase_all || prog_cmd == PCMD_BLOCK_ERASE))
    begin
      blk_read_lock <= 4'hF;
      blk_write_lock <= 4'hF;
      blk_foreign_read_lock <= 4'hF;
      boot_read_lock <= 1'b1;
      boot_write_lock <= 1'b1;
      boot_foreign_read_lock <= 1'b1;
      eeprom_read_lock <= 1'b1;
      eeprom_write_lock <= 1'b1;
      config_write_lock <= 1'b1;
    end
    else if (core_cfg_wr || prog_cfg_wr)
    begin
      // and with old value: a 1 never comes back by a write
      case (wr_addr)
        REG_BLK_RDLOCK: blk_read_lock <= blk_read_lock & wr_byte[3:0];
        REG_BOOT_DATA_RDLOCK:
        begin
          eeprom_read_lock <= eeprom_read_lock & wr_byte[BIT_EEPROM_READ_LOCK];
          boot_read_lock <= boot_read_lock & wr_byte[BIT_BOOT_READ_LOCK];
        end
        REG_BLK_WRLOCK: blk_write_lock <= blk_write_lock & wr_byte[3:0];
        REG_BOOT_DATA_CFG_WRLOCK:
        begin
          eeprom_write_lock <= eeprom_write_lock & wr_byte[BIT_EEPROM_WRITE_LOCK];
          boot_write_lock <= boot_write_lock & wr_byte[BIT_BOOT_WRITE_LOCK];
          if (prog_cfg_wr)
            config_write_lock <= config_write_lock & wr_byte[BIT_CONFIG_WRITE_LOCK];
        end
        REG_BLK_FRLOCK: blk_foreign_read_lock <= blk_foreign_read_lock & wr_byte[3:0];
        REG_BOOT_FRLOCK:
          boot_foreign_read_lock <= boot_foreign_read_lock & wr_byte[BIT_BOOT_FOREIGN_READ_LOCK];
        default: ;
      endcase
    end
  end
endmodule

// ==== dv/code_protect_properties.sv ====
// concurrent checks on the code protection block ports
`timescale 1ns/1ns
module code_protect_properties #(
  parameter int MEM_KBYTES = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [21:0] table_pointer,
  input wire logic [21:0] pc,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] table_latch,
  input wire logic table_done,
  input wire logic mem_write_en,
  input wire logic cfg_write_refused,
  input wire logic prog_req,
  input wire logic prog_refused,
  input wire logic [7:0] prog_rdata,
  input wire logic prog_done
);
  import prot_pkg::*;
  // block index; anything past the array counts as no block
  function automatic logic [2:0] blk(input logic [21:0] a);
    if (32'(a) >= 1024 * MEM_KBYTES) return BLK_NONE;
    if (a <= BOOT_END) return BLK_BOOT;
    if (a < BLK1_BASE) return 3'h1;
    if (a < BLK2_BASE) return 3'h2;
    if (a < BLK3_BASE) return 3'h3;
    return 3'h4;
  endfunction
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_table_done_next: assert property (
    (table_read_op || table_write_op) |=> table_done) else $error("table op unanswered");
  chk_prog_done_next: assert property (
    prog_req |=> prog_done) else $error("programmer request unanswered");
  chk_refused_no_data: assert property (
    prog_refused |-> prog_done && prog_rdata == 8'h00) else $error("refusal leaked data");
  chk_unimpl_reads_zero: assert property (
    table_read_op && blk(table_pointer) == BLK_NONE && table_pointer <= 22'h1FFFFF
    |=> table_latch == 8'h00) else $error("unimplemented read not zero");
  chk_own_block_read: assert property (
    table_read_op && blk(table_pointer) < BLK_NONE && blk(table_pointer) == blk(pc)
    |=> table_latch == $past(mem_rdata)) else $error("own block read lost data");
  chk_id_read_open: assert property (
    table_read_op && table_pointer >= ID_BASE && table_pointer <= ID_LAST
    |=> table_latch == $past(mem_rdata)) else $error("id read lost data");
  chk_write_en_cause: assert property (
    mem_write_en |-> table_write_op) else $error("array write without table write");
  chk_cfg_refuse_scope: assert property (
    cfg_write_refused |-> table_write_op && table_pointer >= CFG_BASE
    && table_pointer <= CFG_LAST) else $error("config refusal outside config space");
  // main scenarios reached
  cover property (table_read_op && blk(table_pointer) != blk(pc));
  cover property (prog_refused);
  cover property (cfg_write_refused);
endmodule
bind code_protect code_protect_properties #(.MEM_KBYTES(MEM_KBYTES)) u_props (
  .mclk(mclk), .rstn(rstn), .table_read_op(table_read_op),
  .table_write_op(table_write_op), .table_pointer(table_pointer), .pc(pc),
  .mem_rdata(mem_rdata), .table_latch(table_latch), .table_done(table_done),
  .mem_write_en(mem_write_en), .cfg_write_refused(cfg_write_refused),
  .prog_req(prog_req), .prog_refused(prog_refused), .prog_rdata(prog_rdata),
  .prog_done(prog_done));

// ==== dv/prog_mem_model.sv ====
// program memory array model on the far side of the block
`timescale 1ns/1ns
module prog_mem_model (
  input wire logic mclk,
  input wire logic [21:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write_en,
  output logic [7:0] rdata
);
  logic [7:0] cells [256];
  // cells aliase on the low byte; contents start as the inverse of it
  initial for (int i = 0; i < 256; i++) cells[i] = ~8'(i);
  assign rdata = cells[addr[7:0]];
  // only a permitted write may change the array
  always_ff @(posedge mclk) if (write_en) cells[addr[7:0]] <= wdata;
endmodule

// ==== dv/code_protect_tb_top.sv ====
// self-checking bench for the code protection block
`timescale 1ns/1ns
module code_protect_tb_top;
  import prot_pkg::*;
  logic mclk, rstn, table_read_op, table_write_op, core_ee_req, prog_req;
  logic [21:0] table_pointer, pc, prog_addr;
  logic [7:0] table_wdata, mem_rdata, table_latch, prog_wdata, prog_rdata;
  logic table_done, mem_write_en, cfg_write_refused, core_ee_grant;
  logic prog_allow, prog_refused, prog_done;
  pcmd_t prog_cmd;
  int err_count = 0;
  int comparisons = 0;
  code_protect #(.MEM_KBYTES(32)) dut (.mclk(mclk), .rstn(rstn),
    .table_read_op(table_read_op), .table_write_op(table_write_op),
    .table_pointer(table_pointer), .pc(pc), .table_wdata(table_wdata),
    .mem_rdata(mem_rdata), .table_latch(table_latch), .table_done(table_done),
    .mem_write_en(mem_write_en), .cfg_write_refused(cfg_write_refused),
    .core_ee_req(core_ee_req), .core_ee_grant(core_ee_grant), .prog_req(prog_req),
    .prog_cmd(prog_cmd), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_allow(prog_allow), .prog_refused(prog_refused), .prog_rdata(prog_rdata),
    .prog_done(prog_done));
  prog_mem_model u_mem (.mclk(mclk), .addr(table_pointer), .wdata(table_wdata),
    .write_en(mem_write_en), .rdata(mem_rdata));
  always #20 mclk = ~mclk;
  // array contents the model starts with
  function automatic logic [7:0] pat(input logic [21:0] a);
    return ~a[7:0];
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // programmer request; allowed eeprom read data comes from outside, so not checked
  task automatic pg(input pcmd_t c, input logic [21:0] a, input logic [7:0] d,
    input logic r, input logic [7:0] rd);
    @(negedge mclk);
    prog_req = 1'b1;
    prog_cmd = c;
    prog_addr = a;
    prog_wdata = d;
    #1 cmp("prog_allow", {7'h00, ~r}, {7'h00, prog_allow});
    @(negedge mclk);
    prog_req = 1'b0;
    cmp("prog_refused", {7'h00, r}, {7'h00, prog_refused});
    if (r || c != PCMD_EE_READ) cmp("prog_rdata", rd, prog_rdata);
  endtask
  task automatic tr(input logic [21:0] a, input logic [21:0] p, input logic [7:0] e);
    @(negedge mclk);
    table_read_op = 1'b1;
    table_pointer = a;
    pc = p;
    @(negedge mclk);
    table_read_op = 1'b0;
    cmp("table_latch", e, table_latch);
  endtask
  // config writes leave the array enable unchecked
  task automatic tw(input logic [21:0] a, input logic [7:0] d, input logic w, input logic r);
    @(negedge mclk);
    table_write_op = 1'b1;
    table_pointer = a;
    table_wdata = d;
    #1 cmp("cfg_write_refused", {7'h00, r}, {7'h00, cfg_write_refused});
    if (a < CFG_BASE) cmp("mem_write_en", {7'h00, w}, {7'h00, mem_write_en});
    @(negedge mclk);
    table_write_op = 1'b0;
  endtask
  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    {table_read_op, table_write_op, core_ee_req, prog_req} = 4'h0;
    {table_pointer, pc, prog_addr} = 66'h0;
    {table_wdata, prog_wdata} = 16'h0000;
    prog_cmd = PCMD_READ;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    pg(PCMD_READ, REG_BLK_RDLOCK, 8'h00, 1'b0, 8'h0F);
    pg(PCMD_READ, REG_BOOT_DATA_CFG_WRLOCK, 8'h00, 1'b0, 8'hE0);
    pg(PCMD_READ, REG_BOOT_FRLOCK, 8'h00, 1'b0, 8'h40);
    pg(PCMD_WRITE, REG_BLK_RDLOCK, 8'hFE, 1'b0, 8'h00);
    pg(PCMD_WRITE, REG_BLK_RDLOCK, 8'hFF, 1'b0, 8'h00);
    pg(PCMD_READ, REG_BLK_RDLOCK, 8'h00, 1'b0, 8'h0E);
    pg(PCMD_READ, 22'h000300, 8'h00, 1'b1, 8'h00);
    pg(PCMD_WRITE, 22'h000300, 8'h55, 1'b1, 8'h00);
    pg(PCMD_WRITE, 22'h002300, 8'h55, 1'b0, 8'h00);
    tr(22'h000310, 22'h003000, pat(22'h000310));
    pg(PCMD_WRITE, REG_BLK_WRLOCK, 8'hFD, 1'b0, 8'h00);
    tw(22'h001FFF, pat(22'h001FFF), 1'b1, 1'b0);
    tw(22'h002000, pat(22'h002000), 1'b0, 1'b0);
    tw(22'h004010, pat(22'h004010), 1'b1, 1'b0);
    pg(PCMD_WRITE, REG_BOOT_DATA_CFG_WRLOCK, 8'hBF, 1'b0, 8'h00);
    tw(22'h0001FF, pat(22'h0001FF), 1'b0, 1'b0);
    tw(22'h000200, pat(22'h000200), 1'b1, 1'b0);
    pg(PCMD_WRITE, REG_BLK_FRLOCK, 8'hFB, 1'b0, 8'h00);
    tr(22'h004020, 22'h001000, 8'h00);
    tr(22'h004020, 22'h005FFE, pat(22'h004020));
    tr(22'h004000, 22'h003FFE, 8'h00);
    tr(22'h003FFE, 22'h001000, pat(22'h003FFE));
    tr(22'h008000, 22'h000000, 8'h00);
    tr(22'h010055, 22'h000000, 8'h00);
    tr(ID_LAST, 22'h000100, pat(ID_LAST));
    tw(ID_BASE, pat(ID_BASE), 1'b1, 1'b0);
    pg(PCMD_EE_WRITE, 22'h000000, 8'h00, 1'b0, 8'h00);
    pg(PCMD_WRITE, REG_BOOT_DATA_CFG_WRLOCK, 8'h7F, 1'b0, 8'h00);
    pg(PCMD_EE_WRITE, 22'h000000, 8'h00, 1'b1, 8'h00);
    pg(PCMD_EE_READ, 22'h000000, 8'h00, 1'b0, 8'h00);
    pg(PCMD_WRITE, REG_BOOT_DATA_RDLOCK, 8'h7F, 1'b0, 8'h00);
    pg(PCMD_EE_READ, 22'h000000, 8'h00, 1'b1, 8'h00);
    @(negedge mclk);
    core_ee_req = 1'b1;
    #1 cmp("core_ee_grant", 8'h01, {7'h00, core_ee_grant});
    @(negedge mclk);
    core_ee_req = 1'b0;
    tw(REG_BLK_RDLOCK, 8'h0C, 1'b0, 1'b0);
    pg(PCMD_READ, REG_BLK_RDLOCK, 8'h00, 1'b0, 8'h0C);
    tw(REG_BOOT_DATA_CFG_WRLOCK, 8'h00, 1'b0, 1'b0);
    pg(PCMD_READ, REG_BOOT_DATA_CFG_WRLOCK, 8'h00, 1'b0, 8'h20);
    pg(PCMD_WRITE, REG_BOOT_DATA_CFG_WRLOCK, 8'hDF, 1'b0, 8'h00);
    tw(REG_BLK_RDLOCK, 8'h00, 1'b0, 1'b1);
    pg(PCMD_READ, REG_BLK_RDLOCK, 8'h00, 1'b0, 8'h0C);
    // both erase kinds bring every lock back to the erased state
    for (int i = 0; i < 2; i++)
    begin
      pg(i ? PCMD_BLOCK_ERASE : PCMD_CHIP_ERASE, 22'h0, 8'h00, 1'b0, 8'h00);
      pg(PCMD_READ, REG_BLK_RDLOCK, 8'h00, 1'b0, 8'h0F);
      pg(PCMD_READ, REG_BOOT_DATA_CFG_WRLOCK, 8'h00, 1'b0, 8'hE0);
      pg(PCMD_WRITE, REG_BLK_RDLOCK, 8'h00, 1'b0, 8'h00);
    end
    print_verdict();
  end
  // the sequence needs about 110 cycles; 2000 means a hang
  initial
  begin
    #80000;
    err_count++;
    print_verdict();
  end
endmodule
